//--- asab_pkg.sv
// Constants and types shared by both ends of the serial link
package asab_pkg;
    // ************************************************
    // Oversampling ratios, generator ticks per bit
    // ************************************************
    localparam logic [6:0] OS_FAST = 7'h04;
    localparam logic [6:0] OS_MID = 7'h10;
    localparam logic [6:0] OS_SLOW = 7'h40;
    // Autobaud counter runs eight times slower
    localparam int ABD_CLK_SHIFT = 3;
    localparam logic [2:0] ABD_LAST_EDGE = 3'h4;
    localparam logic [7:0] SYNC_CHAR = 8'h55;
    // ************************************************
    // Frame format
    // ************************************************
    localparam logic [3:0] BITS_EIGHT = 4'h8;
    localparam logic [3:0] BITS_NINE = 4'h9;
    localparam logic LINE_IDLE = 1'b1;
    localparam logic LINE_START = 1'b0;
    localparam logic [1:0] BUF_DEPTH = 2'h2;
    // ************************************************
    // State encodings
    // ************************************************
    typedef enum logic [1:0] {
        ABD_IDLE = 2'b00,
        ABD_WAIT_START = 2'b01,
        ABD_WAIT_RISE = 2'b10,
        ABD_COUNT = 2'b11
    } asab_abd_e;
    typedef enum logic [2:0] {
        RX_IDLE = 3'b000,
        RX_START = 3'b001,
        RX_DATA = 3'b010,
        RX_STOP = 3'b011,
        RX_PUSH = 3'b100
    } asab_rx_e;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_START = 2'b01,
        TX_DATA = 2'b10,
        TX_STOP = 2'b11
    } asab_tx_e;
endpackage : asab_pkg

//--- asab_link_if.sv
// Serial link lines between the device and the remote end
`timescale 1ns/10ps
interface asab_link_if;
    // Device transmit line, remote transmit line
    logic dev_tx;
    logic rem_tx;
    modport dev (output dev_tx, input rem_tx);
    modport rem (input dev_tx, output rem_tx);
endinterface : asab_link_if

//--- asab_dev.sv
// Device end: asynchronous serial port with baud measurement
`timescale 1ns/10ps
module asab_dev (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Serial link
    asab_link_if.dev link,
    // Mode and power controls
    input wire logic sync_select,
    input wire logic break_wakeup_enable,
    input wire logic sleep_mode,
    input wire logic high_speed_select,
    input wire logic wide_divisor_select,
    input wire logic nine_bit_select,
    input wire logic receive_enable,
    input wire logic transmit_enable,
    // Autobaud control and status
    input wire logic autobaud_enable_set,
    output logic autobaud_enable,
    output logic autobaud_detect,
    // Divisor register pair
    input wire logic divisor_wr,
    input wire logic [15:0] divisor_wdata,
    output logic [7:0] divisor_low_byte,
    output logic [7:0] divisor_high_byte,
    // Transmit data
    input wire logic [8:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    // Receive data
    output logic [8:0] receive_data_register,
    output logic receive_complete_flag,
    input wire logic receive_data_read
);
    typedef struct packed {
        logic rx_s1;
        logic rx_s2;
        logic rx_prev;
        logic [15:0] div;
        logic [15:0] brg_cnt;
        logic abd_on;
        asab_pkg::asab_abd_e abd_st;
        logic [2:0] abd_edges;
        logic [9:0] abd_pre;
        asab_pkg::asab_rx_e rx_st;
        logic [6:0] rx_tcnt;
        logic [3:0] rx_bit;
        logic [8:0] rx_sh;
        asab_pkg::asab_tx_e tx_st;
        logic [6:0] tx_tcnt;
        logic [3:0] tx_bit;
        logic [8:0] tx_sh;
        logic tx_line;
        logic [1:0][8:0] buf_mem;
        logic [1:0] buf_cnt;
        logic buf_rd;
        logic buf_wr;
    } asab_dev_s;

    asab_dev_s st_r;
    asab_dev_s st_nxt;
    logic rise;
    logic fall;
    logic run;
    logic async_on;
    logic os_tick;
    logic [6:0] os;
    logic [6:0] half;
    logic [9:0] abd_lim;
    logic [3:0] nbits;
    logic [15:0] div_eff;
    logic rx_en;
    logic tx_en;
    logic push_v;
    logic [8:0] push_d;
    logic push_ok;
    logic pop;
    logic buf_full;

    // ************************************************
    // Next-state logic
    // ************************************************
    always_comb begin
        st_nxt = st_r;
        // Pin passes two flops before any logic looks at it
        st_nxt.rx_s1 = link.rem_tx;
        st_nxt.rx_s2 = st_r.rx_s1;
        st_nxt.rx_prev = st_r.rx_s2;
        rise = st_r.rx_s2 & ~st_r.rx_prev;
        fall = ~st_r.rx_s2 & st_r.rx_prev;
        async_on = ~sync_select;
        run = ~sleep_mode | break_wakeup_enable;
        // Ratio and counter clock from the two selects
        if (wide_divisor_select & high_speed_select) begin
            os = asab_pkg::OS_FAST;
        end else if (wide_divisor_select | high_speed_select) begin
            os = asab_pkg::OS_MID;
        end else begin
            os = asab_pkg::OS_SLOW;
        end
        half = os >> 1;
        abd_lim = 10'(({3'h0, os} << asab_pkg::ABD_CLK_SHIFT) - 10'h001);
        nbits = nine_bit_select ? asab_pkg::BITS_NINE : asab_pkg::BITS_EIGHT;
        // Narrow mode ignores the high byte for rate
        div_eff = wide_divisor_select ? st_r.div : {8'h00, st_r.div[7:0]};
        rx_en = receive_enable & async_on & run & ~st_r.abd_on;
        tx_en = transmit_enable & async_on & run;
        push_v = 1'b0;
        push_d = 9'h000;
        buf_full = (st_r.buf_cnt == asab_pkg::BUF_DEPTH);

        // Generator tick: one per divisor+1 cycles
        os_tick = 1'b0;
        if (run) begin
            if (st_r.brg_cnt == 16'h0000) begin
                st_nxt.brg_cnt = div_eff;
                os_tick = 1'b1;
            end else begin
                st_nxt.brg_cnt = st_r.brg_cnt - 16'h0001;
            end
        end
        if (divisor_wr & ~st_r.abd_on) begin
            st_nxt.div = divisor_wdata;
        end

        // Baud measurement sequence
        case (st_r.abd_st)
            asab_pkg::ABD_WAIT_START: begin
                if (fall) begin
                    st_nxt.abd_st = asab_pkg::ABD_WAIT_RISE;
                end
            end
            asab_pkg::ABD_WAIT_RISE: begin
                if (rise) begin
                    st_nxt.abd_st = asab_pkg::ABD_COUNT;
                    st_nxt.abd_edges = 3'h1;
                    st_nxt.abd_pre = 10'h000;
                end
            end
            asab_pkg::ABD_COUNT: begin
                if (st_r.abd_pre == abd_lim) begin
                    st_nxt.abd_pre = 10'h000;
                    st_nxt.div = st_r.div + 16'h0001;
                end else begin
                    st_nxt.abd_pre = st_r.abd_pre + 10'h001;
                end
                if (rise) begin
                    st_nxt.abd_edges = st_r.abd_edges + 3'h1;
                    if (st_r.abd_edges == asab_pkg::ABD_LAST_EDGE) begin
                        st_nxt.abd_st = asab_pkg::ABD_IDLE;
                        st_nxt.abd_on = 1'b0;
                        st_nxt.div = st_r.div;
                        push_v = 1'b1;
                    end
                end
            end
            default: begin
            end
        endcase
        // Leaving async mode or arming wakeup aborts
        if (st_r.abd_on & (~async_on | break_wakeup_enable)) begin
            st_nxt.abd_on = 1'b0;
            st_nxt.abd_st = asab_pkg::ABD_IDLE;
        end
        if (autobaud_enable_set & async_on & ~break_wakeup_enable) begin
            st_nxt.abd_on = 1'b1;
            st_nxt.abd_st = asab_pkg::ABD_WAIT_START;
            st_nxt.div = 16'h0000;
            st_nxt.abd_pre = 10'h000;
            st_nxt.abd_edges = 3'h0;
        end

        // Receiver: mid-bit sampling, stalls when buffer full
        case (st_r.rx_st)
            asab_pkg::RX_IDLE: begin
                if (rx_en & fall) begin
                    st_nxt.rx_st = asab_pkg::RX_START;
                    st_nxt.rx_tcnt = 7'h00;
                end
            end
            asab_pkg::RX_START: begin
                if (os_tick) begin
                    st_nxt.rx_tcnt = st_r.rx_tcnt + 7'h01;
                    if (st_r.rx_tcnt == half - 7'h01) begin
                        st_nxt.rx_tcnt = 7'h00;
                        st_nxt.rx_bit = 4'h0;
                        // A glitch shorter than half a bit is dropped
                        st_nxt.rx_st = st_r.rx_s2 ? asab_pkg::RX_IDLE : asab_pkg::RX_DATA;
                    end
                end
            end
            asab_pkg::RX_DATA: begin
                if (os_tick) begin
                    st_nxt.rx_tcnt = st_r.rx_tcnt + 7'h01;
                    if (st_r.rx_tcnt == os - 7'h01) begin
                        st_nxt.rx_tcnt = 7'h00;
                        st_nxt.rx_sh = {st_r.rx_s2, st_r.rx_sh[8:1]};
                        st_nxt.rx_bit = st_r.rx_bit + 4'h1;
                        if (st_r.rx_bit == nbits - 4'h1) begin
                            st_nxt.rx_st = asab_pkg::RX_STOP;
                        end
                    end
                end
            end
            asab_pkg::RX_STOP: begin
                if (os_tick) begin
                    st_nxt.rx_tcnt = st_r.rx_tcnt + 7'h01;
                    if (st_r.rx_tcnt == os - 7'h01) begin
                        st_nxt.rx_st = asab_pkg::RX_PUSH;
                    end
                end
            end
            asab_pkg::RX_PUSH: begin
                push_v = 1'b1;
                push_d = nine_bit_select ? st_r.rx_sh : {1'b0, st_r.rx_sh[8:1]};
                if (~buf_full) begin
                    st_nxt.rx_st = asab_pkg::RX_IDLE;
                end
            end
            default: begin
                st_nxt.rx_st = asab_pkg::RX_IDLE;
            end
        endcase
        if (st_r.abd_on) begin
            st_nxt.rx_st = asab_pkg::RX_IDLE;
        end

        // Transmitter: start, data LSB first, stop
        tx_ready = tx_en & (st_r.tx_st == asab_pkg::TX_IDLE);
        if (tx_ready & tx_valid) begin
            st_nxt.tx_sh = tx_data;
            st_nxt.tx_line = asab_pkg::LINE_START;
            st_nxt.tx_st = asab_pkg::TX_START;
            st_nxt.tx_tcnt = 7'h00;
        end else if ((st_r.tx_st != asab_pkg::TX_IDLE) & os_tick) begin
            st_nxt.tx_tcnt = st_r.tx_tcnt + 7'h01;
            if (st_r.tx_tcnt == os - 7'h01) begin
                st_nxt.tx_tcnt = 7'h00;
                case (st_r.tx_st)
                    asab_pkg::TX_START: begin
                        st_nxt.tx_line = st_r.tx_sh[0];
                        st_nxt.tx_sh = st_r.tx_sh >> 1;
                        st_nxt.tx_bit = 4'h0;
                        st_nxt.tx_st = asab_pkg::TX_DATA;
                    end
                    asab_pkg::TX_DATA: begin
                        if (st_r.tx_bit == nbits - 4'h1) begin
                            st_nxt.tx_line = asab_pkg::LINE_IDLE;
                            st_nxt.tx_st = asab_pkg::TX_STOP;
                        end else begin
                            st_nxt.tx_line = st_r.tx_sh[0];
                            st_nxt.tx_sh = st_r.tx_sh >> 1;
                            st_nxt.tx_bit = st_r.tx_bit + 4'h1;
                        end
                    end
                    default: begin
                        st_nxt.tx_st = asab_pkg::TX_IDLE;
                    end
                endcase
            end
        end

        // Two-entry buffer; push and pop together both act unless it is full
        pop = receive_data_read & (st_r.buf_cnt != 2'h0);
        push_ok = push_v & ~buf_full;
        if (push_ok) begin
            st_nxt.buf_mem[st_r.buf_wr] = push_d;
            st_nxt.buf_wr = ~st_r.buf_wr;
        end
        if (pop) begin
            st_nxt.buf_rd = ~st_r.buf_rd;
        end
        st_nxt.buf_cnt = st_r.buf_cnt + {1'b0, push_ok} - {1'b0, pop};
    end

    // ************************************************
    // State register
    // ************************************************
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_r <= '0;
            st_r.rx_s1 <= asab_pkg::LINE_IDLE;
            st_r.rx_s2 <= asab_pkg::LINE_IDLE;
            st_r.rx_prev <= asab_pkg::LINE_IDLE;
            st_r.tx_line <= asab_pkg::LINE_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from state flops
    assign link.dev_tx = st_r.tx_line;
    assign autobaud_enable = st_r.abd_on;
    assign autobaud_detect = (st_r.abd_st != asab_pkg::ABD_IDLE);
    assign divisor_low_byte = st_r.div[7:0];
    assign divisor_high_byte = st_r.div[15:8]; // Zero check is software's job
    assign receive_data_register = st_r.buf_mem[st_r.buf_rd];
    assign receive_complete_flag = (st_r.buf_cnt != 2'h0);
endmodule : asab_dev

//--- asab_rem.sv
// Remote end: plain 8-bit asynchronous transceiver
`timescale 1ns/10ps
module asab_rem (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Serial link
    asab_link_if.rem link,
    // Bit period in mclk cycles
    input wire logic [15:0] bit_cycles,
    // Send side
    input wire logic [7:0] send_data,
    input wire logic send_valid,
    input wire logic send_sync,
    output logic send_ready,
    // Receive side
    output logic [7:0] recv_data,
    output logic recv_valid,
    output logic recv_frame_err
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
        asab_pkg::asab_tx_e tx_st;
        logic [15:0] tx_cnt;
        logic [3:0] tx_bit;
        logic [7:0] tx_sh;
        logic tx_line;
        asab_pkg::asab_rx_e rx_st;
        logic [15:0] rx_cnt;
        logic [3:0] rx_bit;
        logic [7:0] rx_sh;
        logic [7:0] rx_out;
        logic rx_vld;
        logic rx_err;
    } asab_rem_s;

    asab_rem_s st_r;
    asab_rem_s st_nxt;
    logic [15:0] last;
    logic [15:0] mid;

    // ************************************************
    // Next-state logic
    // ************************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = link.dev_tx;
        st_nxt.s2 = st_r.s1;
        st_nxt.prev = st_r.s2;
        st_nxt.rx_vld = 1'b0;
        last = bit_cycles - 16'h0001;
        mid = {1'b0, bit_cycles[15:1]} - 16'h0001;
        send_ready = (st_r.tx_st == asab_pkg::TX_IDLE);
        // Sync request wins over data when both arrive
        if (send_ready & (send_valid | send_sync)) begin
            st_nxt.tx_sh = send_sync ? asab_pkg::SYNC_CHAR : send_data;
            st_nxt.tx_line = asab_pkg::LINE_START;
            st_nxt.tx_st = asab_pkg::TX_START;
            st_nxt.tx_cnt = 16'h0000;
        end else if (~send_ready) begin
            st_nxt.tx_cnt = st_r.tx_cnt + 16'h0001;
            if (st_r.tx_cnt == last) begin
                st_nxt.tx_cnt = 16'h0000;
                case (st_r.tx_st)
                    asab_pkg::TX_START: begin
                        st_nxt.tx_line = st_r.tx_sh[0];
                        st_nxt.tx_sh = st_r.tx_sh >> 1;
                        st_nxt.tx_bit = 4'h0;
                        st_nxt.tx_st = asab_pkg::TX_DATA;
                    end
                    asab_pkg::TX_DATA: begin
                        if (st_r.tx_bit == asab_pkg::BITS_EIGHT - 4'h1) begin
                            st_nxt.tx_line = asab_pkg::LINE_IDLE;
                            st_nxt.tx_st = asab_pkg::TX_STOP;
                        end else begin
                            st_nxt.tx_line = st_r.tx_sh[0];
                            st_nxt.tx_sh = st_r.tx_sh >> 1;
                            st_nxt.tx_bit = st_r.tx_bit + 4'h1;
                        end
                    end
                    default: begin
                        st_nxt.tx_st = asab_pkg::TX_IDLE;
                    end
                endcase
            end
        end

        // Receiver, sampled mid-bit
        st_nxt.rx_cnt = st_r.rx_cnt + 16'h0001;
        case (st_r.rx_st)
            asab_pkg::RX_START: begin
                if (st_r.rx_cnt == mid) begin
                    st_nxt.rx_cnt = 16'h0000;
                    st_nxt.rx_bit = 4'h0;
                    st_nxt.rx_st = st_r.s2 ? asab_pkg::RX_IDLE : asab_pkg::RX_DATA;
                end
            end
            asab_pkg::RX_DATA: begin
                if (st_r.rx_cnt == last) begin
                    st_nxt.rx_cnt = 16'h0000;
                    st_nxt.rx_sh = {st_r.s2, st_r.rx_sh[7:1]};
                    st_nxt.rx_bit = st_r.rx_bit + 4'h1;
                    if (st_r.rx_bit == asab_pkg::BITS_EIGHT - 4'h1) begin
                        st_nxt.rx_st = asab_pkg::RX_STOP;
                    end
                end
            end
            asab_pkg::RX_STOP: begin
                if (st_r.rx_cnt == last) begin
                    st_nxt.rx_out = st_r.rx_sh;
                    st_nxt.rx_vld = 1'b1;
                    st_nxt.rx_err = ~st_r.s2;
                    st_nxt.rx_st = asab_pkg::RX_IDLE;
                end
            end
            default: begin
                st_nxt.rx_cnt = 16'h0000;
                st_nxt.rx_st = asab_pkg::RX_IDLE;
                if (~st_r.s2 & st_r.prev) begin
                    st_nxt.rx_st = asab_pkg::RX_START;
                end
            end
        endcase
    end

    // ************************************************
    // State register
    // ************************************************
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_r <= '0;
            st_r.s1 <= asab_pkg::LINE_IDLE;
            st_r.s2 <= asab_pkg::LINE_IDLE;
            st_r.prev <= asab_pkg::LINE_IDLE;
            st_r.tx_line <= asab_pkg::LINE_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign link.rem_tx = st_r.tx_line;
    assign recv_data = st_r.rx_out;
    assign recv_valid = st_r.rx_vld;
    assign recv_frame_err = st_r.rx_err;
endmodule : asab_rem

//--- asab_props.sv
// Concurrent checks on the device transmit line and autobaud controls
`timescale 1ns/10ps
module asab_props (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Device line and controls
    input wire logic dev_tx,
    input wire logic sync_select,
    input wire logic break_wakeup_enable,
    input wire logic autobaud_enable_set,
    input wire logic tx_valid,
    input wire logic divisor_wr,
    // Device status
    input wire logic autobaud_enable,
    input wire logic [7:0] divisor_low_byte,
    input wire logic [7:0] divisor_high_byte,
    input wire logic tx_ready,
    input wire logic receive_complete_flag
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    // ****
    // Sequences
    // ****
    sequence s_arm_ok;
        autobaud_enable_set && !sync_select && !break_wakeup_enable;
    endsequence
    sequence s_launch;
        tx_valid && tx_ready;
    endsequence
    // Shortest start bit is four ticks at divisor zero
    sequence s_start_bit;
        (!dev_tx && !tx_ready) [*4];
    endsequence
    // ****
    // Properties
    // ****
    a_arm_clears_div: assert property (s_arm_ok |=> autobaud_enable && {divisor_high_byte, divisor_low_byte} == 16'h0000)
        else $error("arming left divisor or enable wrong");
    a_arm_refused: assert property (autobaud_enable_set && (sync_select || break_wakeup_enable) && !autobaud_enable |=> !autobaud_enable)
        else $error("arming taken in a forbidden mode");
    a_abort_on_mode: assert property (autobaud_enable && (sync_select || break_wakeup_enable) |-> ##[1:3] !autobaud_enable)
        else $error("measurement survived a forbidden mode");
    // Completion, not abort, must leave a word to read
    a_done_raises_flag: assert property ($fell(autobaud_enable) && !$past(sync_select) && !$past(break_wakeup_enable) |-> receive_complete_flag)
        else $error("completion without receive flag");
    a_divisor_holds: assert property (!autobaud_enable && !divisor_wr && !autobaud_enable_set |=> $stable({divisor_high_byte, divisor_low_byte}))
        else $error("divisor moved while idle");
    a_no_rx_word: assert property (autobaud_enable && !receive_complete_flag |=> !receive_complete_flag || !autobaud_enable)
        else $error("word buffered during measurement");
    a_tx_start_low: assert property (s_launch |=> s_start_bit)
        else $error("start bit missing or short");
    a_tx_idle_high: assert property (tx_ready |-> dev_tx)
        else $error("line not high while idle");
endmodule : asab_props

//--- tb_async_serial_autobaud.sv
// Self-checking bench joining the device and the remote end
`timescale 1ns/10ps
module tb_async_serial_autobaud;
    // ****
    // Stimulus and observed signals
    // ****
    logic mclk = 1'b0, sys_rst = 1'b1, sync_select = 1'b0, break_wakeup_enable = 1'b0, sleep_mode = 1'b0;
    logic high_speed_select = 1'b0, wide_divisor_select = 1'b0, nine_bit_select = 1'b0;
    logic receive_enable = 1'b1, transmit_enable = 1'b1, autobaud_enable_set = 1'b0;
    logic divisor_wr = 1'b0, tx_valid = 1'b0, receive_data_read = 1'b0, send_valid = 1'b0, send_sync = 1'b0;
    logic [15:0] divisor_wdata = 16'h0000, bit_cycles = 16'h0034;
    logic [8:0] tx_data = 9'h000, receive_data_register;
    logic [7:0] send_data = 8'h00, divisor_low_byte, divisor_high_byte, recv_data, got_rem;
    logic autobaud_enable, autobaud_detect, tx_ready, receive_complete_flag, send_ready, recv_valid, recv_frame_err;
    int err_total = 0, n_compared = 0, r;
    asab_link_if lnk ();
    asab_dev asab_dev_i (.mclk, .sys_rst, .link(lnk), .sync_select, .break_wakeup_enable, .sleep_mode,
        .high_speed_select, .wide_divisor_select, .nine_bit_select, .receive_enable, .transmit_enable,
        .autobaud_enable_set, .autobaud_enable, .autobaud_detect, .divisor_wr, .divisor_wdata,
        .divisor_low_byte, .divisor_high_byte, .tx_data, .tx_valid, .tx_ready, .receive_data_register,
        .receive_complete_flag, .receive_data_read);
    asab_rem asab_rem_i (.mclk, .sys_rst, .link(lnk), .bit_cycles, .send_data, .send_valid, .send_sync,
        .send_ready, .recv_data, .recv_valid, .recv_frame_err);
    asab_props asab_props_i (.mclk, .sys_rst, .dev_tx(lnk.dev_tx), .sync_select, .break_wakeup_enable,
        .autobaud_enable_set, .tx_valid, .divisor_wr, .autobaud_enable, .divisor_low_byte,
        .divisor_high_byte, .tx_ready, .receive_complete_flag);
    // 125 MHz clock
    initial begin
        forever #4 mclk = ~mclk;
    end
    // Remote receive pulse lasts one cycle, so latch it here
    always @(posedge mclk) begin
        if (recv_valid === 1'b1) got_rem <= recv_data;
    end
    // ****
    // Tasks
    // ****
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Measured count may land one either side of the ideal
    task automatic chk_near(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (!(got === exp || got === exp - 16'h0001 || got === exp + 16'h0001)) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_near
    function automatic logic pick(input int w);
        case (w)
            0: return tx_ready;
            1: return send_ready;
            2: return autobaud_enable;
            default: return receive_complete_flag;
        endcase
    endfunction : pick
    task automatic wait_sig(input int w, input logic lvl);
        int n;
        n = 0;
        while (pick(w) !== lvl && n < 20000) begin
            @(negedge mclk);
            n++;
        end
        if (n == 20000) chk(16'h0001, 16'h0000);
    endtask : wait_sig
    // One-cycle strobe: 0 arm, 1 divisor write, 2 data read
    task automatic strobe(input int w);
        @(negedge mclk);
        autobaud_enable_set = (w == 0);
        divisor_wr = (w == 1);
        receive_data_read = (w == 2);
        @(negedge mclk);
        {autobaud_enable_set, divisor_wr, receive_data_read} = 3'b000;
    endtask : strobe
    // Sends one word and samples each bit centre on the wire
    task automatic dev_send(input logic [8:0] d, input int nb);
        logic e;
        wait_sig(0, 1'b1);
        tx_data = d;
        tx_valid = 1'b1;
        @(negedge mclk);
        tx_valid = 1'b0;
        repeat (26) @(negedge mclk);
        for (int i = 0; i <= nb + 1; i++) begin
            if (i > 0) repeat (52) @(negedge mclk);
            e = (i == 0) ? 1'b0 : (i <= nb) ? d[i-1] : 1'b1;
            chk(16'(lnk.dev_tx), 16'(e));
        end
    endtask : dev_send
    task automatic rem_send(input logic [7:0] d, input logic sy);
        wait_sig(1, 1'b1);
        send_data = d;
        send_valid = !sy;
        send_sync = sy;
        @(negedge mclk);
        {send_valid, send_sync} = 2'b00;
    endtask : rem_send
    task automatic tally_and_finish();
        $display("Compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish
    // Watchdog, well beyond the roughly 15000 cycles expected
    initial begin
        repeat (60000) @(posedge mclk);
        err_total++;
        tally_and_finish();
    end
    // ****
    // Test sequence
    // ****
    initial begin
        repeat (2) @(negedge mclk);
        sys_rst = 1'b0;
        chk(16'({autobaud_enable, receive_complete_flag, lnk.dev_tx}), 16'h0001);
        // Every select pairing times a sync character of twelve ticks
        // Sync reception runs with the transmitter left off
        transmit_enable = 1'b0;
        for (int k = 0; k < 4; k++) begin
            {wide_divisor_select, high_speed_select} = k[1:0];
            r = (k == 0) ? 64 : (k == 3) ? 4 : 16;
            divisor_wdata = 16'h00ff;
            strobe(1);
            chk({divisor_high_byte, divisor_low_byte}, 16'h00ff);
            strobe(0);
            chk({divisor_high_byte, divisor_low_byte}, 16'h0000);
            chk(16'({autobaud_detect, autobaud_enable}), 16'h0003);
            bit_cycles = 16'(r * 12);
            rem_send(8'h55, 1'b1);
            wait_sig(2, 1'b0);
            chk_near({divisor_high_byte, divisor_low_byte}, 16'h000c);
            chk(16'({autobaud_detect, receive_complete_flag, receive_data_register}), 16'h0200);
            strobe(2);
            chk(16'(receive_complete_flag), 16'h0000);
        end
        transmit_enable = 1'b1;
        $display("Test step autobaud finished");
        // Forbidden modes refuse arming; a write mid-measurement is ignored
        for (int k = 1; k < 3; k++) begin
            {sync_select, break_wakeup_enable} = k[1:0];
            strobe(0);
            chk(16'(autobaud_enable), 16'h0000);
            {sync_select, break_wakeup_enable} = 2'b00;
        end
        strobe(0);
        divisor_wdata = 16'h1234;
        strobe(1);
        chk({divisor_high_byte, divisor_low_byte}, 16'h0000);
        break_wakeup_enable = 1'b1;
        repeat (4) @(negedge mclk);
        chk(16'(autobaud_enable), 16'h0000);
        // Sleep keeps the port alive only while break wakeup is armed
        sleep_mode = 1'b1;
        @(negedge mclk);
        chk(16'(tx_ready), 16'h0001);
        break_wakeup_enable = 1'b0;
        @(negedge mclk);
        chk(16'(tx_ready), 16'h0000);
        sleep_mode = 1'b0;
        $display("Test step refusal finished");
        // Fast wide rate, divisor 12 gives a 52-cycle bit
        divisor_wdata = 16'h000c;
        // Remote must run at the same 52-cycle bit, or its samples drift
        bit_cycles = 16'h0034;
        strobe(1);
        dev_send(9'h0a6, 8);
        repeat (52) @(negedge mclk);
        chk(16'({recv_frame_err, got_rem}), 16'h00a6);
        nine_bit_select = 1'b1;
        dev_send(9'h155, 9);
        nine_bit_select = 1'b0;
        // Three words with no reads fill the buffer, then drain
        rem_send(8'h3c, 1'b0);
        rem_send(8'hc3, 1'b0);
        rem_send(8'h81, 1'b0);
        repeat (600) @(negedge mclk);
        for (int i = 0; i < 3; i++) begin
            wait_sig(3, 1'b1);
            chk(16'(receive_data_register), (i == 0) ? 16'h003c : (i == 1) ? 16'h00c3 : 16'h0081);
            strobe(2);
        end
        chk(16'(receive_complete_flag), 16'h0000);
        $display("Test step traffic finished");
        tally_and_finish();
    end
endmodule : tb_async_serial_autobaud
